// ### tapdet_regs.svh
// constants for the tap event detector
// Function
// - axis select: 00 none, 01 X, 10 Y, 11 Z.
// - inverted peak window, 1 sample per LSB up to 31; zero disables.
// - pre-shock quiet threshold, 4 bits at 62.5 mg per LSB.
// - post-shock quiet duration, six bits split over two registers, 4 samples per LSB.
// - shock wait, six bits, 2 samples per LSB.
// - post-shock quiet threshold, 4 bits at 62.5 mg per LSB.
// - multi-tap window: 0 means 16 samples, else 32 samples per LSB.
// - defer bit 0: flag every detected tap at once.
// - defer bit 1: flag highest level only, at top level, or at window end if no tap completes on that sample.
// - peak threshold, six bits at 62.5 mg per LSB; peak must exceed it.
// - single, double, triple enables default 0; disabled levels never reported.
// - rebound wait: zero disables, else 2 samples per LSB.
// - pre-quiet start index into 14-sample history, from oldest.
// - pre-quiet sample count up to 14; zero disables pre-shock check.
`ifndef TAPDET_REGS_SVH
`define TAPDET_REGS_SVH
`define TAPDET_ADDR_CFG0  8'h6F
`define TAPDET_ADDR_CFG1  8'h70
`define TAPDET_ADDR_CFG2  8'h71
`define TAPDET_ADDR_CFG3  8'h72
`define TAPDET_ADDR_CFG4  8'h73
`define TAPDET_ADDR_CFG5  8'h74
`define TAPDET_ADDR_CFG6  8'h75
`define TAPDET_CFG_RESET  8'h00
`define TAPDET_HIST_LEN   14
`define TAPDET_LSB_MG     10'd625
`define TAPDET_POST_MUL   4
`define TAPDET_WAIT_MUL   2
`define TAPDET_REB_MUL    2
`define TAPDET_WIN_MUL    32
`define TAPDET_WIN_ZERO   9'd16
`endif

// ### tapdet_pkg.sv
// types of the tap event detector
package tapdet_pkg;
  typedef enum logic [2:0] {
    ST_IDLE   = 3'b000,
    ST_INV    = 3'b001,
    ST_WAIT   = 3'b010,
    ST_REB    = 3'b011,
    ST_POST   = 3'b100
  } tapdet_phase_t;

  typedef struct packed {
    logic [7:0]                 cfg0;
    logic [7:0]                 cfg1;
    logic [7:0]                 cfg2;
    logic [7:0]                 cfg3;
    logic [7:0]                 cfg4;
    logic [7:0]                 cfg5;
    logic [7:0]                 cfg6;
    logic [7:0]                 rdata;
    tapdet_phase_t              phase;
    logic [8:0]                 cnt;
    logic                       peak_pos;
    logic [8:0]                 win_cnt;
    logic [1:0]                 taps;
    logic [13:0][15:0]          hist;
    logic                       ev_single;
    logic                       ev_double;
    logic                       ev_triple;
  } tapdet_state_t;
endpackage

// ### tapdet_top.sv
// tap event detector with its configuration registers
`timescale 1ns/1ps
`include "tapdet_regs.svh"
module tapdet_top #(
  parameter int DW = 16
) (
  input  wire logic          CLOCK,
  input  wire logic          RESET,
  input  wire logic          REG_WE,
  input  wire logic          REG_RE,
  input  wire logic [7:0]    REG_ADDR,
  input  wire logic [7:0]    REG_WDATA,
  output logic      [7:0]    REG_RDATA,
  input  wire logic          SAMPLE_VALID,
  input  wire logic [DW-1:0] ACC_X,
  input  wire logic [DW-1:0] ACC_Y,
  input  wire logic [DW-1:0] ACC_Z,
  output logic               SINGLE_TAP,
  output logic               DOUBLE_TAP,
  output logic               TRIPLE_TAP
);
  tapdet_pkg::tapdet_state_t s_r;
  tapdet_pkg::tapdet_state_t s_nxt;

  // samples are signed, in mg; thresholds in units of 62.5 mg
  function automatic logic [15:0] mag(input logic [15:0] v);
    mag = v[15] ? 16'(~v + 16'h0001) : v;
  endfunction

  function automatic logic [15:0] ths_mg(input logic [5:0] f);
    ths_mg = 16'((32'(f) * 32'(`TAPDET_LSB_MG)) / 32'd10);
  endfunction

  logic [15:0] smp;
  logic [15:0] amag;
  logic        above_peak;
  logic        pre_ok;
  logic        axis_on;
  logic [8:0]  win_len;
  logic [2:0]  top_lvl;
  logic [15:0] pre_ths;
  logic [15:0] post_ths;
  logic [4:0]  st_idx;
  logic [4:0]  n_cnt;

  always_comb begin
    unique case (s_r.cfg0[7:6])
      2'b01:   smp = 16'(ACC_X);
      2'b10:   smp = 16'(ACC_Y);
      2'b11:   smp = 16'(ACC_Z);
      default: smp = 16'h0000;
    endcase
  end

  assign axis_on    = s_r.cfg0[7:6] != 2'b00;
  assign amag       = mag(smp);
  assign above_peak = amag > ths_mg(s_r.cfg4[5:0]);
  assign pre_ths    = ths_mg({2'b00, s_r.cfg1[7:4]});
  assign post_ths   = ths_mg({2'b00, s_r.cfg3[7:4]});
  assign st_idx     = {1'b0, s_r.cfg6[7:4]};
  assign n_cnt      = {1'b0, s_r.cfg6[3:0]};
  assign win_len    = (s_r.cfg3[3:0] == 4'h0) ? `TAPDET_WIN_ZERO : 9'(s_r.cfg3[3:0] * `TAPDET_WIN_MUL);
  assign top_lvl    = s_r.cfg5[7] ? 3'd3 : s_r.cfg5[6] ? 3'd2 : s_r.cfg5[5] ? 3'd1 : 3'd0;

  // pre-shock check over the history window, oldest entry at index 0
  always_comb begin
    pre_ok = 1'b1;
    for (int i = 0; i < `TAPDET_HIST_LEN; i++) begin
      if (5'(i) >= st_idx && 5'(i) < 5'(st_idx + n_cnt) && mag(s_r.hist[i]) > pre_ths) begin
        pre_ok = 1'b0;
      end
    end
    if (n_cnt == 5'd0) begin
      pre_ok = 1'b1;
    end
  end

  logic       tap_done;
  logic [1:0] new_taps;

  always_comb begin
    s_nxt           = s_r;
    s_nxt.ev_single = 1'b0;
    s_nxt.ev_double = 1'b0;
    s_nxt.ev_triple = 1'b0;
    s_nxt.rdata     = 8'h00;
    tap_done        = 1'b0;
    new_taps        = s_r.taps;
    if (REG_RE) begin
      unique case (REG_ADDR)
        `TAPDET_ADDR_CFG0: s_nxt.rdata = {s_r.cfg0[7:1], 1'b0};
        `TAPDET_ADDR_CFG1: s_nxt.rdata = s_r.cfg1;
        `TAPDET_ADDR_CFG2: s_nxt.rdata = s_r.cfg2;
        `TAPDET_ADDR_CFG3: s_nxt.rdata = s_r.cfg3;
        `TAPDET_ADDR_CFG4: s_nxt.rdata = {s_r.cfg4[7], 1'b0, s_r.cfg4[5:0]};
        `TAPDET_ADDR_CFG5: s_nxt.rdata = s_r.cfg5;
        `TAPDET_ADDR_CFG6: s_nxt.rdata = s_r.cfg6;
        default:           s_nxt.rdata = 8'h00;
      endcase
    end
    if (REG_WE) begin
      unique case (REG_ADDR)
        `TAPDET_ADDR_CFG0: s_nxt.cfg0 = {REG_WDATA[7:1], 1'b0};
        `TAPDET_ADDR_CFG1: s_nxt.cfg1 = REG_WDATA;
        `TAPDET_ADDR_CFG2: s_nxt.cfg2 = REG_WDATA;
        `TAPDET_ADDR_CFG3: s_nxt.cfg3 = REG_WDATA;
        `TAPDET_ADDR_CFG4: s_nxt.cfg4 = {REG_WDATA[7], 1'b0, REG_WDATA[5:0]};
        `TAPDET_ADDR_CFG5: s_nxt.cfg5 = REG_WDATA;
        `TAPDET_ADDR_CFG6: s_nxt.cfg6 = REG_WDATA;
        default:           s_nxt.cfg0 = s_r.cfg0;
      endcase
    end
    if (SAMPLE_VALID && axis_on) begin
      for (int i = 0; i < `TAPDET_HIST_LEN - 1; i++) begin
        s_nxt.hist[i] = s_r.hist[i+1];
      end
      s_nxt.hist[`TAPDET_HIST_LEN-1] = smp;
      // multi-tap window runs while a sequence is open
      if (s_r.taps != 2'd0) begin
        if (s_r.win_cnt >= win_len) begin
          if (s_r.cfg4[7]) begin
            s_nxt.ev_single = (s_r.taps == 2'd1) && s_r.cfg5[5];
            s_nxt.ev_double = (s_r.taps == 2'd2) && s_r.cfg5[6];
            s_nxt.ev_triple = (s_r.taps == 2'd3) && s_r.cfg5[7];
          end
          s_nxt.taps    = 2'd0;
          s_nxt.win_cnt = 9'd0;
        end else begin
          s_nxt.win_cnt = 9'(s_r.win_cnt + 9'd1);
        end
      end
      s_nxt.cnt = 9'(s_r.cnt + 9'd1);
      unique case (s_r.phase)
        tapdet_pkg::ST_IDLE: begin
          if (above_peak && pre_ok) begin
            s_nxt.peak_pos = ~smp[15];
            s_nxt.cnt      = 9'd0;
            s_nxt.phase    = (s_r.cfg0[5:1] != 5'd0) ? tapdet_pkg::ST_INV : tapdet_pkg::ST_WAIT;
          end
        end
        tapdet_pkg::ST_INV: begin
          if (above_peak && (~smp[15] != s_r.peak_pos)) begin
            s_nxt.cnt   = 9'd0;
            s_nxt.phase = tapdet_pkg::ST_WAIT;
          end else if (s_r.cnt >= 9'(s_r.cfg0[5:1])) begin
            s_nxt.phase = tapdet_pkg::ST_IDLE;
          end
        end
        tapdet_pkg::ST_WAIT: begin
          if (s_r.cnt >= 9'(s_r.cfg2[5:0] * `TAPDET_WAIT_MUL)) begin
            s_nxt.cnt   = 9'd0;
            s_nxt.phase = (s_r.cfg5[4:0] != 5'd0) ? tapdet_pkg::ST_REB : tapdet_pkg::ST_POST;
          end
        end
        tapdet_pkg::ST_REB: begin
          if (s_r.cnt >= 9'(s_r.cfg5[4:0] * `TAPDET_REB_MUL)) begin
            s_nxt.cnt   = 9'd0;
            s_nxt.phase = tapdet_pkg::ST_POST;
          end
        end
        tapdet_pkg::ST_POST: begin
          if (amag > post_ths) begin
            s_nxt.phase = tapdet_pkg::ST_IDLE;
          end else if (s_r.cnt >= 9'({s_r.cfg2[7:6], s_r.cfg1[3:0]} * `TAPDET_POST_MUL)) begin
            s_nxt.phase = tapdet_pkg::ST_IDLE;
            tap_done    = 1'b1;
          end
        end
        default: s_nxt.phase = tapdet_pkg::ST_IDLE;
      endcase
      if (tap_done) begin
        new_taps      = (s_r.taps == 2'd3 || s_r.win_cnt >= win_len) ? 2'd1 : 2'(s_r.taps + 2'd1);
        s_nxt.taps    = new_taps;
        s_nxt.win_cnt = 9'd0;
        s_nxt.ev_single = 1'b0;
        s_nxt.ev_double = 1'b0;
        s_nxt.ev_triple = 1'b0;
        if (!s_r.cfg4[7]) begin
          s_nxt.ev_single = (new_taps == 2'd1) && s_r.cfg5[5];
          s_nxt.ev_double = (new_taps == 2'd2) && s_r.cfg5[6];
          s_nxt.ev_triple = (new_taps == 2'd3) && s_r.cfg5[7];
        end else if (3'(new_taps) >= top_lvl) begin
          s_nxt.ev_single = (new_taps == 2'd1) && s_r.cfg5[5];
          s_nxt.ev_double = (new_taps == 2'd2) && s_r.cfg5[6];
          s_nxt.ev_triple = (new_taps == 2'd3) && s_r.cfg5[7];
          s_nxt.taps      = 2'd0;
        end
      end
    end
    if (!axis_on) begin
      s_nxt.phase   = tapdet_pkg::ST_IDLE;
      s_nxt.taps    = 2'd0;
      s_nxt.win_cnt = 9'd0;
    end
  end

  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      s_r       <= '0;
      s_r.cfg0  <= `TAPDET_CFG_RESET;
      s_r.phase <= tapdet_pkg::ST_IDLE;
    end else begin
      s_r <= s_nxt;
    end
  end

  assign REG_RDATA  = s_r.rdata;
  assign SINGLE_TAP = s_r.ev_single;
  assign DOUBLE_TAP = s_r.ev_double;
  assign TRIPLE_TAP = s_r.ev_triple;
endmodule

// ### tapdet_host.sv
// host model that drives the register strobes
`timescale 1ns/1ps
module tapdet_host (
  input wire logic clock,
  output logic     we,
  output logic     re,
  output logic [7:0] addr,
  output logic [7:0] wdata
);
  initial begin
    we = 1'b0;
    re = 1'b0;
    addr = 8'h00;
    wdata = 8'h00;
  end
  task automatic acc(input logic w, input logic [7:0] a, input logic [7:0] d);
    @(posedge clock);
    we <= w;
    re <= !w;
    addr <= a;
    wdata <= d;
    @(posedge clock);
    we <= 1'b0;
    re <= 1'b0;
  endtask
  // both quiet thresholds always written nonzero
  task automatic cfg(input logic [1:0] ax, input logic [2:0] en, input logic df);
    acc(1'b1, 8'h6F, {ax, 6'h00});
    acc(1'b1, 8'h70, 8'h10);
    acc(1'b1, 8'h71, 8'h01);
    acc(1'b1, 8'h72, 8'h20);
    acc(1'b1, 8'h73, {df, 7'h08});
    acc(1'b1, 8'h74, {en, 5'h00});
    acc(1'b1, 8'h75, 8'h00);
  endtask
endmodule

// ### tapdet_chk_properties.sv
// port checker for the tap event detector
`timescale 1ns/1ps
module tapdet_chk (
  input wire logic       CLOCK,
  input wire logic       RESET,
  input wire logic       REG_WE,
  input wire logic       REG_RE,
  input wire logic [7:0] REG_ADDR,
  input wire logic [7:0] REG_WDATA,
  input wire logic [7:0] REG_RDATA,
  input wire logic       SAMPLE_VALID,
  input wire logic       SINGLE_TAP,
  input wire logic       DOUBLE_TAP,
  input wire logic       TRIPLE_TAP
);
  logic [1:0] axis_r;
  logic [2:0] en_r;
  wire        any_tap = SINGLE_TAP | DOUBLE_TAP | TRIPLE_TAP;
  always_ff @(posedge CLOCK or posedge RESET) begin
    if (RESET) begin
      axis_r <= 2'h0;
      en_r <= 3'h0;
    end else if (REG_WE && REG_ADDR == 8'h6F) begin
      axis_r <= REG_WDATA[7:6];
    end else if (REG_WE && REG_ADDR == 8'h74) begin
      en_r <= REG_WDATA[7:5];
    end
  end
  default clocking cb @(posedge CLOCK); endclocking
  default disable iff (RESET);
  sequence s_pulse; any_tap ##1 !any_tap; endsequence
  property p_idle_rd; !$past(REG_RE) |-> REG_RDATA == 8'h00; endproperty
  property p_axis_rd; REG_RE && !REG_WE && REG_ADDR == 8'h6F |=> REG_RDATA[7:6] == axis_r; endproperty
  property p_en_rd; REG_RE && !REG_WE && REG_ADDR == 8'h74 |=> REG_RDATA[7:5] == en_r; endproperty
  property p_axis_off; axis_r == 2'h0 && $past(axis_r) == 2'h0 |-> !any_tap; endproperty
  property p_en_mask; any_tap |-> ({TRIPLE_TAP, DOUBLE_TAP, SINGLE_TAP} & ~$past(en_r)) == 3'h0; endproperty
  property p_after_smp; any_tap |-> $past(SAMPLE_VALID); endproperty
  property p_onehot; any_tap |-> $onehot0({TRIPLE_TAP, DOUBLE_TAP, SINGLE_TAP}); endproperty
  property p_pulse; any_tap |-> s_pulse; endproperty
  a_idle_rd: assert property (p_idle_rd) else $error("read data not zero");
  a_axis_rd: assert property (p_axis_rd) else $error("axis readback wrong");
  a_en_rd: assert property (p_en_rd) else $error("enable readback wrong");
  a_axis_off: assert property (p_axis_off) else $error("tap with no axis");
  a_en_mask: assert property (p_en_mask) else $error("disabled level flagged");
  a_after_smp: assert property (p_after_smp) else $error("tap without sample");
  a_onehot: assert property (p_onehot) else $error("two levels at once");
  a_pulse: assert property (p_pulse) else $error("tap flag too long");
endmodule
bind tapdet_top tapdet_chk i_chk (.CLOCK(CLOCK), .RESET(RESET), .REG_WE(REG_WE), .REG_RE(REG_RE),
  .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA), .REG_RDATA(REG_RDATA), .SAMPLE_VALID(SAMPLE_VALID),
  .SINGLE_TAP(SINGLE_TAP), .DOUBLE_TAP(DOUBLE_TAP), .TRIPLE_TAP(TRIPLE_TAP));

// ### tap_event_detector_bench.sv
// self-checking bench for the tap event detector
`timescale 1ns/1ps
module tap_event_detector_bench;
  logic        clock = 1'b0;
  logic        reset = 1'b1;
  logic        we, re, sv, st, dt, tt;
  logic        re_d = 1'b0;
  logic [1:0]  sel = 2'h3;
  logic [7:0]  addr, wdata, rdata, d;
  logic [15:0] ax, ay, az;
  logic [7:0]  rd_q[$];
  logic [2:0]  tap_q[$];
  int          fail_count = 0;
  int          tests_run = 0;
  int          seed = 89795;
  tapdet_host i_host (.clock(clock), .we(we), .re(re), .addr(addr), .wdata(wdata));
  tapdet_top i_dut (.CLOCK(clock), .RESET(reset), .REG_WE(we), .REG_RE(re), .REG_ADDR(addr),
    .REG_WDATA(wdata), .REG_RDATA(rdata), .SAMPLE_VALID(sv), .ACC_X(ax), .ACC_Y(ay), .ACC_Z(az),
    .SINGLE_TAP(st), .DOUBLE_TAP(dt), .TRIPLE_TAP(tt));
  initial forever #4 clock = ~clock;
  task automatic report(input string n, input logic [7:0] e, input logic [7:0] g);
    tests_run++;
    if (g !== e) begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic chk_rd(input logic [7:0] e, input logic [7:0] g);
    report("rdata", e, g);
  endtask
  task automatic chk_tap(input logic [2:0] g);
    if (tap_q.size() == 0) report("tap", 8'h00, {5'h00, g});
    else report("tap", {5'h00, tap_q.pop_front()}, {5'h00, g});
  endtask
  task automatic end_sim();
    $display("checks %0d mismatches %0d", tests_run, fail_count);
    if (fail_count == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rd_q.push_back(e);
    i_host.acc(1'b0, a, 8'h00);
  endtask
  // unselected axes carry a large value so a wrong axis never settles
  task automatic smp(input logic [15:0] v);
    @(posedge clock);
    sv <= 1'b1;
    ax <= sel == 2'h1 ? v : 16'h7000;
    ay <= sel == 2'h2 ? v : 16'h7000;
    az <= sel == 2'h3 ? v : 16'h7000;
    @(posedge clock);
    sv <= 1'b0;
    ax <= 16'($random(seed));
    ay <= 16'($random(seed));
    az <= 16'($random(seed));
  endtask
  task automatic qs(input int n);
    repeat (n) smp(16'($random(seed)) & 16'h001F);
  endtask
  task automatic tap(input logic [15:0] pk);
    smp(pk);
    qs(6);
  endtask
  always @(posedge clock) begin
    if (re_d) chk_rd(rd_q.pop_front(), rdata);
    if ((st | dt | tt) !== 1'b0) chk_tap({tt, dt, st});
    re_d <= re;
  end
  initial begin
    {sv, ax, ay, az} = '0;
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    for (int i = 0; i < 8; i++) rd(8'h6F + i[7:0], 8'h00);
    for (int i = 0; i < 7; i++) begin
      d = 8'($random(seed));
      i_host.acc(1'b1, 8'h6F + i[7:0], d);
      rd(8'h6F + i[7:0], d & (i == 0 ? 8'hFE : i == 4 ? 8'hBF : 8'hFF));
    end
    $display("registers done");
    for (int a = 1; a < 4; a++) begin
      sel = a[1:0];
      i_host.cfg(sel, 3'b011, 1'b0);
      tap_q.push_back(3'b001);
      tap(16'd1000);
      tap_q.push_back(3'b010);
      tap(16'hFC18);
      qs(20);
    end
    i_host.cfg(2'h0, 3'b111, 1'b0);
    tap(16'd1000);
    $display("axes done");
    i_host.cfg(2'h3, 3'b111, 1'b1);
    tap_q.push_back(3'b010);
    repeat (2) tap(16'd1000);
    qs(20);
    tap_q.push_back(3'b100);
    repeat (3) tap(16'd1000);
    qs(20);
    i_host.cfg(2'h3, 3'b100, 1'b0);
    tap_q.push_back(3'b100);
    repeat (3) tap(16'hFC18);
    qs(20);
    $display("levels done");
    // inverted peak, rebound, post duration and pre-shock history all switched on
    i_host.cfg(2'h3, 3'b001, 1'b0);
    i_host.acc(1'b1, 8'h6F, 8'hC6);
    i_host.acc(1'b1, 8'h70, 8'h11);
    i_host.acc(1'b1, 8'h74, 8'h21);
    i_host.acc(1'b1, 8'h75, 8'hA4);
    smp(16'd1000);
    qs(10);
    smp(16'd200);
    smp(16'd1000);
    qs(16);
    smp(16'd1000);
    smp(16'hFC18);
    qs(7);
    smp(16'd300);
    qs(16);
    tap_q.push_back(3'b001);
    smp(16'd1000);
    smp(16'hFC18);
    qs(30);
    $display("phases done");
    report("pending", 8'h00, 8'(tap_q.size()));
    end_sim();
  end
endmodule
